//--- hw/link_failover_controller.sv
// Purpose: keeps one of two master ports of a redundant link pair active
// Assumes: fault indications are levels; port enables drive the port logic
// Notes: switchover disables primary, waits a gap, then enables secondary
`timescale 1ns/1ps

// Notes on behaviour
// - reset starts on healthy primary, secondary off
// - never both master ports enabled together
// - watch active primary, switch on failure
// - disable primary first, enable secondary within 10ms
// - repaired primary waits for secondary loss or reboot
// - report state of both links
// - count cycles with any link state transition, once even if both links change
// - primary receive link failure triggers switchover
// - primary partition causes trigger switchover
// - nonresponder gives only local indications
module link_failover_controller
   import failover_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pri_rx_link_fail,
   input wire logic pri_partition,
   input wire logic pri_remote_fail,
   input wire logic sec_rx_link_fail,
   input wire logic sec_partition,
   input wire logic sec_remote_fail,
   input wire logic sec_disabled,
   output logic pri_enable,
   output logic sec_enable,
   output logic [1:0] pri_state,
   output logic [1:0] sec_state,
   output logic [failover_pkg::CNT_W-1:0] trans_count
);
   import failover_pkg::*;

   // ---------------------------------------------------------------
   // input synchronisation
   // ---------------------------------------------------------------
   logic [6:0] flt_s;
   fault_sync #(.W(7)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in({sec_disabled, sec_remote_fail, sec_partition, sec_rx_link_fail,
                 pri_remote_fail, pri_partition, pri_rx_link_fail}),
      .sync_out(flt_s)
   );

   logic pri_bad;
   logic sec_bad;
   // remote flag is only ever raised by a responder; a nonresponder leaves it low
   assign pri_bad = flt_s[0] | flt_s[1] | flt_s[2];
   assign sec_bad = flt_s[3] | flt_s[4] | flt_s[5] | flt_s[6];

   // fault levels are trusted only once both sync stages refilled after reset
   logic [1:0] warm_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         warm_q <= 2'h0;
      end else begin
         warm_q <= {warm_q[0], 1'h1};
      end
   end

   // ---------------------------------------------------------------
   // selection state machine
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_INIT = 5'b00001,
      ST_PRI = 5'b00010,
      ST_GAP_S = 5'b00100,
      ST_SEC = 5'b01000,
      ST_GAP_P = 5'b10000
   } sel_e;

   sel_e state_q;
   logic [15:0] gap_q;
   localparam logic [15:0] GAP_LAST = 16'(GAP_CYC - 1);

   // state transitions; gap states have both ports off
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_INIT;
      end else begin
         case (state_q)
            ST_INIT: begin
               if (warm_q[1] && !pri_bad) begin
                  state_q <= ST_PRI;
               end else if (warm_q[1] && !sec_bad) begin
                  state_q <= ST_GAP_S;
               end
            end
            ST_PRI: begin
               if (pri_bad) begin
                  state_q <= ST_GAP_S;
               end
            end
            ST_GAP_S: begin
               if (gap_q == GAP_LAST) begin
                  state_q <= ST_SEC;
               end
            end
            ST_SEC: begin
               if (sec_bad) begin
                  state_q <= ST_GAP_P;
               end
            end
            ST_GAP_P: begin
               if (gap_q == GAP_LAST) begin
                  state_q <= pri_bad ? ST_INIT : ST_PRI;
               end
            end
            default: begin
               state_q <= ST_INIT;
            end
         endcase
      end
   end

   // dead time counter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gap_q <= '0;
      end else if ((state_q == ST_GAP_S || state_q == ST_GAP_P) && gap_q != GAP_LAST) begin
         gap_q <= gap_q + 16'h0001;
      end else begin
         gap_q <= '0;
      end
   end

   // port enables decoded from one hot state; never both
   assign pri_enable = (state_q == ST_PRI);
   assign sec_enable = (state_q == ST_SEC);

   // ---------------------------------------------------------------
   // status reporting and transition counter
   // ---------------------------------------------------------------
   function automatic logic [1:0] link_code(input logic en, input logic bad);
      link_code = bad ? LINK_FAILED : (en ? LINK_ACTIVE : LINK_STANDBY);
   endfunction

   logic [1:0] pri_state_q;
   logic [1:0] sec_state_q;
   logic [CNT_W-1:0] trans_q;
   logic [1:0] pri_state_d;
   logic [1:0] sec_state_d;
   assign pri_state_d = link_code(pri_enable, pri_bad);
   assign sec_state_d = link_code(sec_enable, sec_bad);

   // registered link states
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pri_state_q <= LINK_STANDBY;
         sec_state_q <= LINK_STANDBY;
      end else begin
         pri_state_q <= pri_state_d;
         sec_state_q <= sec_state_d;
      end
   end

   // count cycles in which either link state changes; both changing adds one
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trans_q <= TRANS_RST;
      end else if (pri_state_d != pri_state_q || sec_state_d != sec_state_q) begin
         trans_q <= trans_q + 16'h0001;
      end
   end

   assign pri_state = pri_state_q;
   assign sec_state = sec_state_q;
   assign trans_count = trans_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_pri_drop;
      pri_enable ##1 !pri_enable;
   endsequence

   property p_one_hot_enable;
      @(posedge clk) disable iff (sys_rst) !(pri_enable && sec_enable);
   endproperty
   a_one_hot_enable: assert property (p_one_hot_enable)
      else $error("both master ports enabled");

   property p_reset_primary;
      @(posedge clk) $fell(sys_rst) |-> !sec_enable [*3];
   endproperty
   a_reset_primary: assert property (p_reset_primary)
      else $error("secondary enabled right after reset");

   property p_switch_on_fail;
      @(posedge clk) disable iff (sys_rst) pri_enable && pri_bad |=> !pri_enable;
   endproperty
   a_switch_on_fail: assert property (p_switch_on_fail)
      else $error("primary kept after failure");

   // cycles since the primary dropped while the secondary is healthy and still off
   logic pri_en_q;
   logic [16:0] drop_age_q;
   localparam logic [16:0] DROP_AGE_MAX = 17'(SWITCH_MAX_CYC);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pri_en_q <= 1'h0;
      end else begin
         pri_en_q <= pri_enable;
      end
   end

   // saturates at the deadline so a hung switchover keeps the check firing
   always_ff @(posedge clk) begin
      if (sys_rst || sec_enable || sec_bad) begin
         drop_age_q <= '0;
      end else if ((pri_en_q && !pri_enable) ||
                   (drop_age_q != '0 && drop_age_q != DROP_AGE_MAX)) begin
         drop_age_q <= drop_age_q + 17'h0_0001;
      end
   end

   property p_pri_first;
      @(posedge clk) disable iff (sys_rst) s_pri_drop |-> !sec_enable;
   endproperty
   a_pri_first: assert property (p_pri_first)
      else $error("secondary enabled before primary dropped");

   property p_switch_deadline;
      @(posedge clk) disable iff (sys_rst) drop_age_q != DROP_AGE_MAX;
   endproperty
   a_switch_deadline: assert property (p_switch_deadline)
      else $error("secondary not enabled in time");

   property p_sec_sticky;
      @(posedge clk) disable iff (sys_rst) sec_enable && !sec_bad |=> sec_enable;
   endproperty
   a_sec_sticky: assert property (p_sec_sticky)
      else $error("secondary dropped without cause");

   property p_state_report;
      @(posedge clk) disable iff (sys_rst) ##1 pri_state == $past(pri_state_d);
   endproperty
   a_state_report: assert property (p_state_report)
      else $error("primary state report stale");

   property p_count_step;
      @(posedge clk) disable iff (sys_rst)
         (pri_state_d != pri_state_q) |=> trans_count == $past(trans_count) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("transition not counted");

   property p_rx_fail_trigger;
      @(posedge clk) disable iff (sys_rst) pri_enable && flt_s[0] |=> !pri_enable;
   endproperty
   a_rx_fail_trigger: assert property (p_rx_fail_trigger)
      else $error("rx link failure ignored");

   property p_partition_trigger;
      @(posedge clk) disable iff (sys_rst) pri_enable && flt_s[1] |=> !pri_enable;
   endproperty
   a_partition_trigger: assert property (p_partition_trigger)
      else $error("partition ignored");
endmodule // link_failover_controller

//--- hw/failover_pkg.sv
// Purpose: shared constants for the redundant link pair failover controller
// Assumes: 10 MHz system clock
// Notes: times are given in their own unit, cycle counts derived from them
package failover_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   // switchover deadline and the chosen dead time between disable and enable
   localparam int unsigned SWITCH_MAX_US = 10_000;
   localparam int unsigned GAP_US = 3_000;
   localparam int unsigned GAP_CYC = (GAP_US * (CLK_HZ / 1_000_000) > 0) ?
      GAP_US * (CLK_HZ / 1_000_000) : 1;
   localparam int unsigned SWITCH_MAX_CYC = SWITCH_MAX_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W = 16;
   localparam logic [CNT_W-1:0] TRANS_RST = 16'h0000;
   // link state codes reported to management
   localparam logic [1:0] LINK_STANDBY = 2'h0;
   localparam logic [1:0] LINK_ACTIVE = 2'h1;
   localparam logic [1:0] LINK_FAILED = 2'h2;
endpackage

//--- hw/fault_sync.sv
// Purpose: two flop synchroniser for a vector of fault indications
// Assumes: single clock, synchronous reset
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module fault_sync #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // two stage capture
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // fault_sync

//--- tb/remote_port_model.sv
// Purpose: far-end repeater port of one link of the pair
// Assumes: a responder reports loss of its own receive link
// Notes: the port is never disabled, in either role
`timescale 1ns/1ps
module remote_port_model (
   input wire logic clk,
   input wire logic responder,
   input wire logic rx_cut,
   output logic fail_rpt
);
   // a nonresponder stays silent, so only local faults reach the master
   always_ff @(posedge clk) begin
      fail_rpt <= responder & rx_cut;
   end
endmodule // remote_port_model

//--- tb/test_redundant_link_failover.sv
// Purpose: self-checking bench for the link failover controller
// Assumes: 10 MHz clock, full 3 ms dead time between the links
// Notes: far ends are responder or nonresponder models
`timescale 1ns/1ps
module test_redundant_link_failover;
   import failover_pkg::*;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic pri_rx_link_fail = 1'h0;
   logic pri_partition = 1'h0;
   logic sec_partition = 1'h0;
   logic sec_disabled = 1'h0;
   logic pri_cut = 1'h0;
   logic sec_cut = 1'h0;
   logic pri_resp = 1'h1;
   logic pri_remote_fail, sec_remote_fail, pri_enable, sec_enable;
   logic [1:0] pri_state, sec_state;
   logic [CNT_W-1:0] trans_count;
   logic [15:0] lfsr = 16'h6f5c;
   int n_errors = 0;
   int checks = 0;

   always #50 clk = ~clk;

   link_failover_controller u_dut (.clk(clk), .sys_rst(sys_rst),
      .pri_rx_link_fail(pri_rx_link_fail), .pri_partition(pri_partition),
      .pri_remote_fail(pri_remote_fail), .sec_rx_link_fail(sec_cut),
      .sec_partition(sec_partition), .sec_remote_fail(sec_remote_fail),
      .sec_disabled(sec_disabled), .pri_enable(pri_enable), .sec_enable(sec_enable),
      .pri_state(pri_state), .sec_state(sec_state), .trans_count(trans_count));
   remote_port_model u_pri_far (.clk(clk), .responder(pri_resp), .rx_cut(pri_cut),
      .fail_rpt(pri_remote_fail));
   remote_port_model u_sec_far (.clk(clk), .responder(1'h0), .rx_cut(sec_cut),
      .fail_rpt(sec_remote_fail));

   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (n_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // bounded wait for one enable (0 primary, 1 secondary) to reach a level
   task automatic wait_en(input logic which, input logic lvl, input int lim);
      int took;
      took = 0;
      while (((which ? sec_enable : pri_enable) !== lvl) && took <= lim) begin
         @(negedge clk);
         took++;
      end
      if (took > lim) begin
         n_errors++;
         finish_test();
      end
   endtask

   // both master ports enabled would close a repeater loop
   always @(negedge clk) begin
      if (!sys_rst) begin
         check("both_enabled", {15'h0000, pri_enable & sec_enable}, 16'h0000);
      end
   end

   // ------------------------------
   // scenarios
   // ------------------------------
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'h0;
      repeat (6) @(negedge clk);
      check("pri_enable", 16'(pri_enable), 16'h0001);
      check("sec_enable", 16'(sec_enable), 16'h0000);
      check("pri_state", 16'(pri_state), 16'(LINK_ACTIVE));
      check("sec_state", 16'(sec_state), 16'(LINK_STANDBY));
      check("trans_count", trans_count, 16'h0001);
      // standby secondary disabled, then its receive link lost: reported, no switch
      for (int j = 0; j < 2; j++) begin
         @(posedge clk);
         sec_disabled <= (j == 0);
         sec_cut <= (j == 1);
         repeat (8) @(negedge clk);
         check("sec_state", 16'(sec_state), 16'(LINK_FAILED));
         check("pri_enable", 16'(pri_enable), 16'h0001);
         @(posedge clk);
         sec_disabled <= 1'h0;
         sec_cut <= 1'h0;
         repeat (8) @(negedge clk);
         check("sec_state", 16'(sec_state), 16'(LINK_STANDBY));
      end
      check("trans_count", trans_count, 16'h0005);
      // nonresponder far end loses its receive link: nothing is seen
      @(posedge clk);
      pri_resp <= 1'h0;
      pri_cut <= 1'h1;
      lfsr = lfsr_next(lfsr);
      repeat (8 + lfsr[3:0]) @(negedge clk);
      check("pri_enable", 16'(pri_enable), 16'h0001);
      check("trans_count", trans_count, 16'h0005);
      @(posedge clk);
      pri_cut <= 1'h0;
      pri_resp <= 1'h1;
      pri_rx_link_fail <= 1'h1;
      // primary goes off first, secondary follows inside the deadline
      wait_en(1'h0, 1'h0, 5);
      check("sec_enable", 16'(sec_enable), 16'h0000);
      wait_en(1'h1, 1'h1, SWITCH_MAX_CYC);
      repeat (2) @(negedge clk);
      check("pri_state", 16'(pri_state), 16'(LINK_FAILED));
      check("sec_state", 16'(sec_state), 16'(LINK_ACTIVE));
      check("trans_count", trans_count, 16'h0007);
      // a repaired primary stays off and is reported as standby
      @(posedge clk);
      pri_rx_link_fail <= 1'h0;
      lfsr = lfsr_next(lfsr);
      repeat (50 + lfsr[5:0]) @(negedge clk);
      check("pri_enable", 16'(pri_enable), 16'h0000);
      check("pri_state", 16'(pri_state), 16'(LINK_STANDBY));
      check("trans_count", trans_count, 16'h0008);
      // secondary partitioned or disabled hands traffic back to the primary
      @(posedge clk);
      lfsr = lfsr_next(lfsr);
      sec_partition <= ~lfsr[0];
      sec_disabled <= lfsr[0];
      wait_en(1'h1, 1'h0, 5);
      wait_en(1'h0, 1'h1, SWITCH_MAX_CYC);
      repeat (2) @(negedge clk);
      check("pri_enable", 16'(pri_enable), 16'h0001);
      check("pri_state", 16'(pri_state), 16'(LINK_ACTIVE));
      check("sec_state", 16'(sec_state), 16'(LINK_FAILED));
      check("trans_count", trans_count, 16'h000a);
      // fresh reset, then a responder report or a partition on the primary
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         sys_rst <= 1'h1;
         sec_partition <= 1'h0;
         sec_disabled <= 1'h0;
         pri_cut <= 1'h0;
         pri_partition <= 1'h0;
         repeat (20) @(posedge clk);
         sys_rst <= 1'h0;
         repeat (6) @(negedge clk);
         check("pri_enable", 16'(pri_enable), 16'h0001);
         check("trans_count", trans_count, 16'h0001);
         @(posedge clk);
         pri_cut <= (k == 0);
         pri_partition <= (k == 1);
         wait_en(1'h0, 1'h0, 6);
         check("sec_enable", 16'(sec_enable), 16'h0000);
         repeat (2) @(negedge clk);
         check("pri_state", 16'(pri_state), 16'(LINK_FAILED));
      end
      finish_test();
   end
endmodule // test_redundant_link_failover
